// *** inc/epv_pkg.sv ***
package epv_pkg;

  // ==========================================================
  // Image layout
  localparam int IMAGE_BITS = 192;
  localparam int WORD_BITS = 16;
  localparam int WORD_COUNT = IMAGE_BITS / WORD_BITS;
  localparam logic [7:0] LAST_BIT = 8'hbf;
  localparam logic [7:0] IMAGE_END = 8'hc0;
  localparam logic [3:0] LAST_IN_WORD = 4'hf;
  localparam logic [3:0] LAST_WORD = 4'hb;

  // ==========================================================
  // Timing figures, in their own units
  localparam real SYS_CLK_MHZ = 10.0;
  localparam real TPS_MIN_MS = 3.5;
  localparam real TPS_MAX_MS = 4.5;
  localparam real TPH1_MS = 3.5;
  localparam real TPBW_MS = 4.0;
  localparam real TPROG_MS = 4.0;
  localparam real TWC_MS = 50.0;
  localparam real TCLKL_US = 50.0;
  localparam real TCLKH_US = 50.0;
  localparam real TDH_US = 30.0;
  localparam real TDV_US = 30.0;

  // ==========================================================
  // Cycle counts; least times round up, longest round down
  localparam int CNT_W = 20;
  typedef logic [CNT_W-1:0] epv_cnt_type;
  localparam int TPS_MIN_CYC = int'($ceil(TPS_MIN_MS * 1000.0 * SYS_CLK_MHZ));
  localparam int TPS_MAX_CYC = int'($floor(TPS_MAX_MS * 1000.0 * SYS_CLK_MHZ));
  localparam int TPS_MID_CYC = (TPS_MIN_CYC + TPS_MAX_CYC) / 2;
  localparam int TPH1_CYC = int'($ceil(TPH1_MS * 1000.0 * SYS_CLK_MHZ));
  localparam int TPBW_CYC = int'($ceil(TPBW_MS * 1000.0 * SYS_CLK_MHZ));
  localparam int ERASE_CYC = int'($floor(TPBW_MS * 1000.0 * SYS_CLK_MHZ));
  localparam int WRITE_CYC = int'($floor(TPROG_MS * 1000.0 * SYS_CLK_MHZ));
  localparam int TWC_CYC = int'($ceil(TWC_MS * 1000.0 * SYS_CLK_MHZ));
  localparam epv_cnt_type TCLKL_CYC =
    epv_cnt_type'(int'($ceil(TCLKL_US * SYS_CLK_MHZ)));
  localparam epv_cnt_type TCLKH_CYC =
    epv_cnt_type'(int'($ceil(TCLKH_US * SYS_CLK_MHZ)));
  localparam epv_cnt_type TDH_CYC =
    epv_cnt_type'(int'($ceil(TDH_US * SYS_CLK_MHZ)));
  localparam epv_cnt_type TDV_CYC =
    epv_cnt_type'(int'($ceil(TDV_US * SYS_CLK_MHZ)));

endpackage

// *** inc/epv_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface epv_if;
  logic button_clock_a;
  logic button_clock_b;
  logic button_low_a;
  logic button_low_b;
  logic dev_data_out;
  logic dev_data_oe;
  logic prg_data_out;
  logic prg_data_oe;
  logic data_line;

  // Shared data wire; weak pull-down when nobody drives it
  assign data_line = dev_data_oe ? dev_data_out :
                     (prg_data_oe ? prg_data_out : 1'b0);

  modport device (
    input button_clock_a, button_clock_b, button_low_a, button_low_b,
    input data_line,
    output dev_data_out, dev_data_oe
  );

  modport programmer (
    output button_clock_a, button_clock_b, button_low_a, button_low_b,
    output prg_data_out, prg_data_oe,
    input data_line
  );
endinterface

`default_nettype wire

// *** hw/epv_device.sv ***
// Contract
// - Session moves exactly 192 bits into array
// - Entry: button high, then data raised
// - Button high time bounded before data rise
// - Entry bulk-clears array; programmer waits
// - 16-bit words clocked by button, data in
// - Internal write after each word; programmer pauses
// - Verify: button clocks, device drives data out
// - No readback without fresh programming
// - Only one readback, right after programming
// - Attached circuitry never pulls data high
// - Low button at fall selects sync transmit
`timescale 1ns/1ps
`default_nettype none

module epv_device #(
  parameter epv_pkg::epv_cnt_type SETUP_MIN_CYC =
    epv_pkg::epv_cnt_type'(epv_pkg::TPS_MIN_CYC),
  parameter epv_pkg::epv_cnt_type SETUP_MAX_CYC =
    epv_pkg::epv_cnt_type'(epv_pkg::TPS_MAX_CYC),
  parameter epv_pkg::epv_cnt_type ERASE_CYC =
    epv_pkg::epv_cnt_type'(epv_pkg::ERASE_CYC),
  parameter epv_pkg::epv_cnt_type WRITE_CYC =
    epv_pkg::epv_cnt_type'(epv_pkg::WRITE_CYC)
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  epv_if.device link,
  output logic mode_prog,
  output logic mode_sync_tx,
  output logic write_busy,
  output logic verify_done,
  output logic [1:0] sync_button_code
);
  import epv_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ARMED, ST_SYNC_TX, ST_ERASE,
    ST_LOAD, ST_WRITE, ST_VERIFY, ST_DONE
  } epv_dev_state_type;

  // ==========================================================
  // Pin synchronisers
  logic [4:0] meta;
  logic [4:0] pins;
  logic clk_prev;
  logic clk_now;
  logic clk_rise;
  logic clk_fall;
  logic data_in;
  logic low_any;

  // Two stages; only the second is read by logic
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= 5'h00;
      pins <= 5'h00;
      clk_prev <= 1'b0;
    end else begin
      meta <= {link.button_clock_a, link.button_clock_b,
               link.button_low_a, link.button_low_b, link.data_line};
      pins <= meta;
      clk_prev <= clk_now;
    end
  end

  // Either clock-capable button acts as the clock line
  assign clk_now = pins[4] | pins[3];
  assign low_any = pins[2] | pins[1];
  assign data_in = pins[0];
  assign clk_rise = clk_now & ~clk_prev;
  assign clk_fall = ~clk_now & clk_prev;

  // ==========================================================
  // Sequencer state
  epv_dev_state_type state, next_state;
  epv_cnt_type cnt, next_cnt;
  logic [7:0] idx, next_idx;
  logic [WORD_BITS-1:0] shreg, next_shreg;
  logic [WORD_BITS-1:0] mem [WORD_COUNT];
  logic [WORD_BITS-1:0] next_mem [WORD_COUNT];
  logic dout, next_dout;
  logic doe, next_doe;
  logic [1:0] next_code;

  // Status decode, applied to the next state only
  function automatic logic is_prog(epv_dev_state_type s);
    return (s == ST_ERASE) || (s == ST_LOAD) ||
           (s == ST_WRITE) || (s == ST_VERIFY);
  endfunction

  function automatic logic is_busy(epv_dev_state_type s);
    return (s == ST_ERASE) || (s == ST_WRITE);
  endfunction

  // Next-state logic for the whole programming session
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_idx = idx;
    next_shreg = shreg;
    next_mem = mem;
    next_dout = dout;
    next_doe = doe;
    next_code = sync_button_code;
    case (state)
      ST_IDLE: begin
        if (clk_now && !data_in) begin
          // Saturate so a long hold cannot wrap into the window
          if (cnt != '1) begin
            next_cnt = cnt + 1'b1;
          end
        end else if (clk_now && data_in && cnt >= SETUP_MIN_CYC &&
                     cnt <= SETUP_MAX_CYC) begin
          next_state = ST_ARMED;
          next_cnt = '0;
        end else begin
          next_cnt = '0;
        end
      end
      ST_ARMED: begin
        if (!data_in && clk_now) begin
          next_state = ST_IDLE;
        end else if (clk_fall) begin
          if (low_any) begin
            next_state = ST_SYNC_TX;
            next_code = pins[2:1];
          end else begin
            next_state = ST_ERASE;
            for (int w = 0; w < WORD_COUNT; w++) begin
              next_mem[w] = '0;
            end
          end
        end
      end
      ST_SYNC_TX: begin
        // Transmitter proper lives elsewhere; wait for idle pins
        if (!clk_now && !data_in) begin
          next_state = ST_IDLE;
        end
      end
      ST_ERASE: begin
        // Pin edges deliberately not looked at here
        next_cnt = cnt + 1'b1;
        if (cnt == ERASE_CYC - 1'b1) begin
          next_state = ST_LOAD;
          next_cnt = '0;
          next_idx = '0;
        end
      end
      ST_LOAD: begin
        if (clk_rise) begin
          next_shreg[idx[3:0]] = data_in;
          if (idx[3:0] == LAST_IN_WORD) begin
            next_state = ST_WRITE;
          end else begin
            next_idx = idx + 1'b1;
          end
        end
      end
      ST_WRITE: begin
        next_cnt = cnt + 1'b1;
        if (cnt == WRITE_CYC - 1'b1) begin
          next_cnt = '0;
          next_mem[idx[7:4]] = shreg;
          if (idx[7:4] == LAST_WORD) begin
            // Readback is reachable only from here
            next_state = ST_VERIFY;
            next_idx = '0;
          end else begin
            next_state = ST_LOAD;
            next_idx = idx + 1'b1;
          end
        end
      end
      ST_VERIFY: begin
        if (clk_rise) begin
          next_doe = 1'b1;
          next_dout = mem[idx[7:4]][idx[3:0]];
        end else if (clk_fall && doe) begin
          if (idx == LAST_BIT) begin
            next_state = ST_DONE;
            next_doe = 1'b0;
            next_dout = 1'b0;
          end else begin
            next_idx = idx + 1'b1;
          end
        end
      end
      ST_DONE: begin
        // No path back to readback without a fresh session
        if (!clk_now && !data_in) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Registers only
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      cnt <= '0;
      idx <= '0;
      shreg <= '0;
      for (int w = 0; w < WORD_COUNT; w++) begin
        mem[w] <= '0;
      end
      dout <= 1'b0;
      doe <= 1'b0;
      sync_button_code <= 2'h0;
      mode_prog <= 1'b0;
      mode_sync_tx <= 1'b0;
      write_busy <= 1'b0;
      verify_done <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      idx <= next_idx;
      shreg <= next_shreg;
      mem <= next_mem;
      dout <= next_dout;
      doe <= next_doe;
      sync_button_code <= next_code;
      mode_prog <= is_prog(next_state);
      mode_sync_tx <= (next_state == ST_SYNC_TX);
      write_busy <= is_busy(next_state);
      verify_done <= (next_state == ST_DONE);
    end
  end

  assign link.dev_data_out = dout;
  assign link.dev_data_oe = doe;

endmodule // epv_device

`default_nettype wire

// *** hw/epv_programmer.sv ***
`timescale 1ns/1ps
`default_nettype none

module epv_programmer #(
  parameter epv_pkg::epv_cnt_type SETUP_CYC =
    epv_pkg::epv_cnt_type'(epv_pkg::TPS_MID_CYC),
  parameter epv_pkg::epv_cnt_type HOLD1_CYC =
    epv_pkg::epv_cnt_type'(epv_pkg::TPH1_CYC),
  parameter epv_pkg::epv_cnt_type BULK_CYC =
    epv_pkg::epv_cnt_type'(epv_pkg::TPBW_CYC),
  parameter epv_pkg::epv_cnt_type TWC_CYC =
    epv_pkg::epv_cnt_type'(epv_pkg::TWC_CYC),
  parameter epv_pkg::epv_cnt_type CLKL_CYC = epv_pkg::TCLKL_CYC,
  parameter epv_pkg::epv_cnt_type CLKH_CYC = epv_pkg::TCLKH_CYC,
  parameter epv_pkg::epv_cnt_type DH_CYC = epv_pkg::TDH_CYC,
  parameter epv_pkg::epv_cnt_type DV_CYC = epv_pkg::TDV_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  epv_if.programmer link,
  input wire logic start,
  input wire logic [epv_pkg::IMAGE_BITS-1:0] image,
  output logic busy,
  output logic done,
  output logic verify_ok,
  output logic [epv_pkg::IMAGE_BITS-1:0] readback
);
  import epv_pkg::*;

  typedef enum logic [3:0] {
    PS_IDLE, PS_SETUP, PS_RAISE, PS_BULK, PS_BIT_LOW,
    PS_BIT_HIGH, PS_WRITE_WAIT, PS_RD_HIGH, PS_RD_LOW, PS_FINISH
  } epv_prg_state_type;

  // ==========================================================
  // Data line synchroniser
  logic din_meta;
  logic din;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      din_meta <= 1'b0;
      din <= 1'b0;
    end else begin
      din_meta <= link.data_line;
      din <= din_meta;
    end
  end

  // ==========================================================
  // Sequencer; the divider is the phase counter itself
  epv_prg_state_type state, next_state;
  epv_cnt_type cnt, next_cnt;
  logic [7:0] idx, next_idx;
  logic [IMAGE_BITS-1:0] img, next_img;
  logic [IMAGE_BITS-1:0] next_rb;
  logic bclk, next_bclk;
  logic dout, next_dout;
  logic doe, next_doe;
  logic next_done;
  logic next_ok;

  always_comb begin
    next_state = state;
    next_cnt = cnt + 1'b1;
    next_idx = idx;
    next_img = img;
    next_rb = readback;
    next_bclk = bclk;
    next_dout = dout;
    next_doe = doe;
    next_done = done;
    next_ok = verify_ok;
    case (state)
      PS_IDLE: begin
        next_cnt = '0;
        if (start) begin
          next_state = PS_SETUP;
          next_img = image;
          next_bclk = 1'b1;
          next_doe = 1'b1;
          next_dout = 1'b0;
          next_done = 1'b0;
          next_ok = 1'b0;
        end
      end
      PS_SETUP: begin
        // Mid-window hold keeps margin on both bounds
        if (cnt == SETUP_CYC - 1'b1) begin
          next_state = PS_RAISE;
          next_cnt = '0;
          next_dout = 1'b1;
        end
      end
      PS_RAISE: begin
        if (cnt == HOLD1_CYC - 1'b1) begin
          // Falling edge with low buttons idle selects programming
          next_state = PS_BULK;
          next_cnt = '0;
          next_bclk = 1'b0;
        end
      end
      PS_BULK: begin
        if (cnt == BULK_CYC - 1'b1) begin
          next_state = PS_BIT_LOW;
          next_cnt = '0;
          next_idx = '0;
        end
      end
      PS_BIT_LOW: begin
        // New bit only after the hold time past the falling edge
        if (cnt == DH_CYC - 1'b1) begin
          next_dout = img[idx];
        end
        if (cnt == CLKL_CYC - 1'b1) begin
          next_state = PS_BIT_HIGH;
          next_cnt = '0;
          next_bclk = 1'b1;
        end
      end
      PS_BIT_HIGH: begin
        if (cnt == CLKH_CYC - 1'b1) begin
          next_cnt = '0;
          next_bclk = 1'b0;
          next_idx = idx + 1'b1;
          if (idx[3:0] == LAST_IN_WORD) begin
            next_state = PS_WRITE_WAIT;
          end else begin
            next_state = PS_BIT_LOW;
          end
        end
      end
      PS_WRITE_WAIT: begin
        if (cnt == TWC_CYC - 1'b1) begin
          next_cnt = '0;
          if (idx == IMAGE_END) begin
            // Release the wire before the device starts driving
            next_state = PS_RD_HIGH;
            next_idx = '0;
            next_doe = 1'b0;
            next_dout = 1'b0;
            next_bclk = 1'b1;
          end else begin
            next_state = PS_BIT_LOW;
          end
        end
      end
      PS_RD_HIGH: begin
        if (cnt == DV_CYC - 1'b1) begin
          next_rb[idx] = din;
        end
        if (cnt == CLKH_CYC - 1'b1) begin
          next_state = PS_RD_LOW;
          next_cnt = '0;
          next_bclk = 1'b0;
        end
      end
      PS_RD_LOW: begin
        if (cnt == CLKL_CYC - 1'b1) begin
          next_cnt = '0;
          if (idx == LAST_BIT) begin
            next_state = PS_FINISH;
          end else begin
            next_state = PS_RD_HIGH;
            next_idx = idx + 1'b1;
            next_bclk = 1'b1;
          end
        end
      end
      PS_FINISH: begin
        next_state = PS_IDLE;
        next_done = 1'b1;
        next_ok = (readback == img);
      end
      default: begin
        next_state = PS_IDLE;
      end
    endcase
  end

  // Registers only
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= PS_IDLE;
      cnt <= '0;
      idx <= '0;
      img <= '0;
      readback <= '0;
      bclk <= 1'b0;
      dout <= 1'b0;
      doe <= 1'b0;
      done <= 1'b0;
      verify_ok <= 1'b0;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      idx <= next_idx;
      img <= next_img;
      readback <= next_rb;
      bclk <= next_bclk;
      dout <= next_dout;
      doe <= next_doe;
      done <= next_done;
      verify_ok <= next_ok;
      busy <= (next_state != PS_IDLE);
    end
  end

  // Only one clock button used; low buttons held low throughout
  assign link.button_clock_a = bclk;
  assign link.button_clock_b = 1'b0;
  assign link.button_low_a = 1'b0;
  assign link.button_low_b = 1'b0;
  assign link.prg_data_out = dout;
  assign link.prg_data_oe = doe;

endmodule // epv_programmer

`default_nettype wire

// *** verification/epv_properties.sv ***
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Wire checks on the link between programmer and device
module epv_properties #(
  parameter int SETUP_MIN = 400,
  parameter int SETUP_MAX = 600,
  parameter int ERASE = 300,
  parameter int WRITE = 300,
  parameter int CLKL = 500,
  parameter int CLKH = 500,
  parameter int DV = 300
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic button_clock_a,
  input wire logic button_clock_b,
  input wire logic button_low_a,
  input wire logic button_low_b,
  input wire logic dev_data_out,
  input wire logic dev_data_oe,
  input wire logic prg_data_out,
  input wire logic prg_data_oe,
  input wire logic data_line
);
  import epv_pkg::*;

  epv_cnt_type low_cnt, high_cnt, next_low_cnt, next_high_cnt;
  logic [7:0] wr_cnt, rd_cnt, next_wr_cnt, next_rd_cnt;
  logic clk_q, rise, fall;

  // Phase lengths saturate, so long idle stretches never wrap to zero
  always_comb begin
    rise = button_clock_a && !clk_q;
    fall = !button_clock_a && clk_q;
    next_low_cnt = button_clock_a ? '0 : low_cnt + epv_cnt_type'(~&low_cnt);
    next_high_cnt = !button_clock_a ? '0 :
                    high_cnt + epv_cnt_type'(~&high_cnt);
    next_wr_cnt = wr_cnt + 8'(rise && prg_data_oe);
    next_rd_cnt = rd_cnt + 8'(fall && dev_data_oe);
  end

  // Counters only; one session per reset, so bit counts never clear
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_q <= 1'b0;
      low_cnt <= '1;
      high_cnt <= '0;
      wr_cnt <= 8'h00;
      rd_cnt <= 8'h00;
    end else begin
      clk_q <= button_clock_a;
      low_cnt <= next_low_cnt;
      high_cnt <= next_high_cnt;
      wr_cnt <= next_wr_cnt;
      rd_cnt <= next_rd_cnt;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // ============================================================
  // Assertions
  a_drive_exclusive: assert property (!(dev_data_oe && prg_data_oe))
    else $error("both ends drive the data line");
  a_idle_pulldown: assert property (
    (!dev_data_oe && !prg_data_oe) |-> !data_line)
    else $error("released data line not low");
  a_lows_held: assert property (!button_low_a && !button_low_b)
    else $error("programmer raised a low button");
  a_clk_low_min: assert property (
    $rose(button_clock_a) |-> low_cnt >= CLKL)
    else $error("clock low phase too short");
  a_clk_high_min: assert property (
    $fell(button_clock_a) |-> high_cnt >= CLKH)
    else $error("clock high phase too short");
  a_setup_window: assert property (
    $rose(prg_data_out) && prg_data_oe && button_clock_a
    |-> high_cnt >= SETUP_MIN && high_cnt <= SETUP_MAX)
    else $error("entry setup outside window");
  a_bulk_wait: assert property (
    $rose(button_clock_a) && prg_data_oe && wr_cnt == 8'h01
    |-> low_cnt >= ERASE)
    else $error("data clocked before erase end");
  a_word_pause: assert property (
    $rose(button_clock_a) && prg_data_oe && wr_cnt[3:0] == 4'h1 &&
    wr_cnt > 8'h01 |-> low_cnt >= WRITE)
    else $error("no write pause between words");
  a_bit_count: assert property (wr_cnt <= 8'hc1)
    else $error("more than one image loaded");
  a_one_readback: assert property (rd_cnt <= 8'hc0)
    else $error("more than one readback");
  a_dev_on_rise: assert property (
    $rose(dev_data_oe) |-> button_clock_a)
    else $error("device drives outside high phase");
  a_dev_stable: assert property (
    dev_data_oe && button_clock_a && high_cnt > DV
    |-> $stable(dev_data_out))
    else $error("read bit moved after valid time");
endmodule // epv_properties

`default_nettype wire

// *** verification/encoder_eeprom_program_verify_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Both ends joined; a second device faces the bench directly
module encoder_eeprom_program_verify_tb_top;
  import epv_pkg::*;
  logic sys_clk, rst_b, start, busy, done, verify_ok;
  logic [IMAGE_BITS-1:0] image, img_ref, readback;
  logic mode_prog, mode_sync_tx, write_busy, verify_done;
  logic mode_prog_b, mode_sync_tx_b, write_busy_b, verify_done_b;
  logic [1:0] sync_button_code, code_b, lows;
  logic [IMAGE_BITS:0] exp_q[$];
  logic [IMAGE_BITS:0] note;
  int err_count, n_compared, wr_idx, rd_idx, oe_b_seen, vdone_seen, i, k;
  epv_if link_a();
  epv_if link_b();

  // Shortened counts keep the whole run short; link phases 40 cycles
  localparam int P_SMIN = 32'h190;
  localparam int P_SMAX = 32'h258;
  localparam int P_ERASE = 32'h12c;
  localparam int P_WRITE = 32'h12c;
  localparam int P_SETUP = 32'h1f4;
  localparam int P_HOLD1 = 32'h12c;
  localparam int P_BULK = 32'h136;
  localparam int P_TWC = 32'h190;
  localparam int P_HALF = 32'h28;
  localparam int P_DV = 32'h18;

  epv_device #(.SETUP_MIN_CYC(epv_cnt_type'(P_SMIN)),
    .SETUP_MAX_CYC(epv_cnt_type'(P_SMAX)),
    .ERASE_CYC(epv_cnt_type'(P_ERASE)),
    .WRITE_CYC(epv_cnt_type'(P_WRITE))) i_epv_device (
    .sys_clk(sys_clk), .rst_b(rst_b), .link(link_a),
    .mode_prog(mode_prog), .mode_sync_tx(mode_sync_tx),
    .write_busy(write_busy), .verify_done(verify_done),
    .sync_button_code(sync_button_code));
  epv_device #(.SETUP_MIN_CYC(epv_cnt_type'(P_SMIN)),
    .SETUP_MAX_CYC(epv_cnt_type'(P_SMAX)),
    .ERASE_CYC(epv_cnt_type'(P_ERASE)),
    .WRITE_CYC(epv_cnt_type'(P_WRITE))) i_epv_device_b (
    .sys_clk(sys_clk), .rst_b(rst_b), .link(link_b),
    .mode_prog(mode_prog_b), .mode_sync_tx(mode_sync_tx_b),
    .write_busy(write_busy_b), .verify_done(verify_done_b),
    .sync_button_code(code_b));
  epv_programmer #(.SETUP_CYC(epv_cnt_type'(P_SETUP)),
    .HOLD1_CYC(epv_cnt_type'(P_HOLD1)),
    .BULK_CYC(epv_cnt_type'(P_BULK)), .TWC_CYC(epv_cnt_type'(P_TWC)),
    .CLKL_CYC(epv_cnt_type'(P_HALF)), .CLKH_CYC(epv_cnt_type'(P_HALF)),
    .DH_CYC(epv_cnt_type'(P_DV)),
    .DV_CYC(epv_cnt_type'(P_DV))) i_epv_programmer (
    .sys_clk(sys_clk), .rst_b(rst_b), .link(link_a), .start(start),
    .image(image), .busy(busy), .done(done), .verify_ok(verify_ok),
    .readback(readback));
  epv_properties #(.SETUP_MIN(P_SMIN), .SETUP_MAX(P_SMAX), .ERASE(P_ERASE),
    .WRITE(P_WRITE), .CLKL(P_HALF), .CLKH(P_HALF),
    .DV(P_DV)) i_epv_properties (
    .sys_clk(sys_clk), .rst_b(rst_b),
    .button_clock_a(link_a.button_clock_a),
    .button_clock_b(link_a.button_clock_b),
    .button_low_a(link_a.button_low_a), .button_low_b(link_a.button_low_b),
    .dev_data_out(link_a.dev_data_out), .dev_data_oe(link_a.dev_data_oe),
    .prg_data_out(link_a.prg_data_out), .prg_data_oe(link_a.prg_data_oe),
    .data_line(link_a.data_line));

  // ============================================================
  // Shared tasks
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic chk(input string name, input logic [IMAGE_BITS-1:0] exp,
                     input logic [IMAGE_BITS-1:0] got);
    n_compared++;
    if (exp !== got) begin
      err_count++;
      $display("wrong value %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic test_done;
    $display("compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Bench plays a programmer on the second link, free to misbehave
  task automatic b_pins(input logic clk, input logic oe, input logic d,
                        input logic [1:0] lo);
    link_b.button_clock_a <= clk;
    link_b.button_clock_b <= 1'b0;
    link_b.prg_data_oe <= oe;
    link_b.prg_data_out <= d;
    link_b.button_low_a <= lo[1];
    link_b.button_low_b <= lo[0];
  endtask

  task automatic b_entry(input int setup, input logic [1:0] lo);
    b_pins(1'b1, 1'b1, 1'b0, lo);
    tick(setup);
    b_pins(1'b1, 1'b1, 1'b1, lo);
    tick(300);
    b_pins(1'b0, 1'b1, 1'b1, lo);
    tick(20);
  endtask

  // Link clock of 800 ns: four system cycles per phase
  task automatic b_bits(input int n, input logic d);
    repeat (n) begin
      b_pins(1'b1, 1'b1, d, 2'b00);
      tick(4);
      b_pins(1'b0, 1'b1, d, 2'b00);
      tick(4);
    end
  endtask

  task automatic b_idle;
    b_pins(1'b0, 1'b0, 1'b0, 2'b00);
    tick(20);
  endtask

  // ============================================================
  // Clock, watchdog and wire monitors
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Full session is about 41k cycles with the shortened counts
  initial begin
    tick(60000);
    err_count++;
    test_done();
  end

  // Step past the edge so enable and clock raised together both count
  always @(posedge link_a.button_clock_a) begin
    #1;
    if (link_a.prg_data_oe === 1'b1) begin
      if (wr_idx > 0)
        chk("load bit", IMAGE_BITS'(img_ref[wr_idx-1]), IMAGE_BITS'(link_a.data_line));
      wr_idx++;
    end
  end

  always @(negedge link_a.button_clock_a) begin
    if (link_a.dev_data_oe === 1'b1) begin
      chk("read bit", IMAGE_BITS'(img_ref[rd_idx]), IMAGE_BITS'(link_a.data_line));
      rd_idx++;
    end
  end

  always @(posedge sys_clk) begin
    if (link_b.dev_data_oe === 1'b1)
      oe_b_seen = 1;
    // Done flag drops as soon as the pins go idle, so keep a note
    if (verify_done === 1'b1)
      vdone_seen = 1;
  end

  // Result watcher takes the oldest note when a session ends
  initial begin
    forever begin
      @(posedge done);
      #1;
      if (exp_q.size() == 0) begin
        chk("unexpected done", '0, IMAGE_BITS'(done));
      end else begin
        note = exp_q.pop_front();
        chk("readback", note[IMAGE_BITS-1:0], readback);
        chk("verify_ok", IMAGE_BITS'(note[IMAGE_BITS]), IMAGE_BITS'(verify_ok));
        chk("verify_done", IMAGE_BITS'(1), IMAGE_BITS'(vdone_seen));
      end
    end
  end

  // ============================================================
  // Main sequence
  initial begin
    rst_b = 1'b0;
    start = 1'b0;
    image = '0;
    img_ref = '0;
    b_pins(1'b0, 1'b0, 1'b0, 2'b00);
    void'($urandom(67874));
    tick(20);
    rst_b <= 1'b1;
    tick(2);
    b_bits(16, 1'b0);
    b_entry(200, 2'b00);
    chk("short setup", '0, IMAGE_BITS'({mode_prog_b, mode_sync_tx_b}));
    b_idle();
    b_entry(700, 2'b00);
    chk("long setup", '0, IMAGE_BITS'({mode_prog_b, mode_sync_tx_b}));
    b_idle();
    lows = 2'(1 + $urandom_range(2));
    b_entry(420 + $urandom_range(150), lows);
    chk("sync mode", IMAGE_BITS'(1), IMAGE_BITS'(mode_sync_tx_b));
    chk("sync code", IMAGE_BITS'(lows), IMAGE_BITS'(code_b));
    b_idle();
    b_entry(500, 2'b00);
    chk("prog entry", IMAGE_BITS'(2'b11), IMAGE_BITS'({mode_prog_b, write_busy_b}));
    b_bits(8, 1'b1);
    tick(300);
    chk("erase end", '0, IMAGE_BITS'(write_busy_b));
    b_bits(15, 1'b1);
    chk("edges in erase", '0, IMAGE_BITS'(write_busy_b));
    b_bits(1, 1'b1);
    chk("word write", IMAGE_BITS'(1), IMAGE_BITS'(write_busy_b));
    b_idle();
    for (i = 0; i < IMAGE_BITS / 32; i++)
      img_ref[32*i +: 32] = $urandom();
    exp_q.push_back({1'b1, img_ref});
    image <= img_ref;
    start <= 1'b1;
    tick(1);
    start <= 1'b0;
    tick(60);
    start <= 1'b1;
    tick(1);
    start <= 1'b0;
    for (k = 0; k < 50000 && done !== 1'b1; k++)
      tick(1);
    tick(5);
    chk("bits loaded", IMAGE_BITS'(IMAGE_BITS + 1), IMAGE_BITS'(wr_idx));
    chk("bits read", IMAGE_BITS'(IMAGE_BITS), IMAGE_BITS'(rd_idx));
    chk("refused readback", '0, IMAGE_BITS'(oe_b_seen));
    chk("notes left", '0, IMAGE_BITS'(exp_q.size()));
    test_done();
  end
endmodule // encoder_eeprom_program_verify_tb_top

`default_nettype wire
